// *** logic/rhb_host_port.sv ***
// rtc parallel host port with power-fail lockout, interrupt and multi-function output
//
// Contract
// - a read is active only while chip select and read strobe are both low and ends when either rises.
// - a write is active only while chip select and write strobe are both low and ends when either rises.
// - accesses are accepted only while the active-low chip select is low; strobes are active low too.
// - after power failure is detected the strobes and chip select are ignored, but an access in progress completes.
// - five select lines choose the location, and they are ignored once power failure is detected.
// - the data lines float whenever the power-fail input is low and no write is in progress.
// - a low power-fail input enters lockout after 30 to 63 us unless a lockout delay is programmed.
// - the interrupt output asserts on a timing or power-fail event whose source is enabled.
// - the interrupt output is active low, open drain, and holds a level until software clears it.
// - writing a one to a status bit clears that source and releases the interrupt for it.
// - there are three interrupt classes, periodic, alarm and power fail, each with mask and status bits.
// - the multi-function output acts either as a second interrupt or as the oscillator output.
// - the multi-function output drives high actively normally and becomes open drain in battery standby.
// - the oscillator runs only while powered and valid crystal-select bits have been written.
`timescale 1ns/1ps
`default_nettype none
module rhb_host_port
  import rhb_pkg::*;
#(
  parameter int LOCKOUT_CYC = rhb_pkg::LOCKOUT_MIN_CYC,
  parameter int XTAL_SEL_W = 2
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic chip_sel_n,
  input wire logic read_n,
  input wire logic write_n,
  input wire logic [rhb_pkg::SEL_W-1:0] register_select_lines,
  input wire logic [rhb_pkg::DATA_W-1:0] host_data_in,
  output logic [rhb_pkg::DATA_W-1:0] host_data_out,
  output logic host_data_oe,
  input wire logic power_fail_in_n,
  input wire logic battery_standby,
  input wire logic power_fail_in_n_detect_en,
  input wire logic lockout_delay_en,
  input wire logic [rhb_pkg::LOCKOUT_CNT_W-1:0] lockout_delay_cyc,
  input wire logic [rhb_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rd_stb,
  output logic reg_wr_stb,
  output logic [rhb_pkg::SEL_W-1:0] reg_addr,
  output logic [rhb_pkg::DATA_W-1:0] reg_wdata,
  input wire logic periodic_evt,
  input wire logic alarm_evt,
  input wire logic [rhb_pkg::NUM_CLASSES-1:0] irq_mask,
  input wire logic [rhb_pkg::NUM_CLASSES-1:0] mfo_mask,
  input wire logic mfo_mode,
  input wire logic osc_clk_in,
  input wire logic [XTAL_SEL_W-1:0] xtal_sel,
  input wire logic xtal_sel_wr,
  output logic [rhb_pkg::NUM_CLASSES-1:0] irq_status,
  output logic lockout,
  output logic osc_run,
  output logic interrupt_out_n,
  output logic interrupt_oe,
  output logic multi_function_out,
  output logic multi_function_oe
);
  import rhb_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int PIN_W = 4 + SEL_W + DATA_W;
  logic [PIN_W-1:0] pins_async;
  logic [PIN_W-1:0] pins_sync;
  logic cs_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic pf_n_s;
  logic osc_s;
  logic [SEL_W-1:0] sel_s;
  logic [DATA_W-1:0] din_s;

  assign pins_async = {chip_sel_n, read_n, write_n, power_fail_in_n, register_select_lines, host_data_in};

  // strobes and power-fail idle high
  rhb_sync #(
    .W(PIN_W),
    .RST_VAL({4'hf, {(SEL_W + DATA_W){1'b0}}})
  ) u_pin_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(pins_async),
    .sync_out(pins_sync)
  );

  rhb_sync #(
    .W(1),
    .RST_VAL(1'b0)
  ) u_osc_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(osc_clk_in),
    .sync_out(osc_s)
  );

  assign {cs_n_s, rd_n_s, wr_n_s, pf_n_s, sel_s, din_s} = pins_sync;

  // ----------------------------------------------------------------
  // power-fail lockout timer
  // ----------------------------------------------------------------
  logic [LOCKOUT_CNT_W-1:0] pf_cnt_reg;
  logic [LOCKOUT_CNT_W-1:0] pf_cnt_next;
  logic lockout_reg;
  logic lockout_next;
  logic [LOCKOUT_CNT_W-1:0] pf_limit;

  // programmed delay replaces the default window
  always_comb
  begin
    pf_limit = LOCKOUT_CNT_W'(LOCKOUT_CYC);
    if (lockout_delay_en)
      pf_limit = lockout_delay_cyc;
    pf_cnt_next = pf_cnt_reg;
    lockout_next = lockout_reg;
    if (pf_n_s)
    begin
      pf_cnt_next = '0;
      lockout_next = 1'b0;
    end
    else if (power_fail_in_n_detect_en && !lockout_reg)
    begin
      if (pf_cnt_reg >= pf_limit - 1'b1)
        lockout_next = 1'b1;
      else
        pf_cnt_next = pf_cnt_reg + 1'b1;
    end
    if (rst)
    begin
      pf_cnt_next = '0;
      lockout_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    pf_cnt_reg <= pf_cnt_next;
    lockout_reg <= lockout_next;
  end

  // ----------------------------------------------------------------
  // access state machine
  // ----------------------------------------------------------------
  rhb_acc_t acc_reg;
  rhb_acc_t acc_next;
  logic rd_active;
  logic wr_active;
  logic [SEL_W-1:0] addr_reg;
  logic [SEL_W-1:0] addr_next;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] wdata_next;
  logic rd_stb_reg;
  logic rd_stb_next;
  logic wr_stb_reg;
  logic wr_stb_next;

  assign rd_active = !cs_n_s && !rd_n_s;
  assign wr_active = !cs_n_s && !wr_n_s;

  // new accesses only start outside lockout; running ones finish
  always_comb
  begin
    acc_next = acc_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rd_stb_next = 1'b0;
    wr_stb_next = 1'b0;
    case (acc_reg)
      RHB_IDLE:
      begin
        if (!lockout_reg && rd_active)
        begin
          acc_next = RHB_READ;
          addr_next = sel_s;
          rd_stb_next = 1'b1;
        end
        else if (!lockout_reg && wr_active)
        begin
          acc_next = RHB_WRITE;
          addr_next = sel_s;
        end
      end
      RHB_READ:
      begin
        if (!rd_active)
          acc_next = RHB_IDLE;
      end
      RHB_WRITE:
      begin
        if (wr_active)
          wdata_next = din_s; // data is sampled only while the strobe is low
        else
        begin
          acc_next = RHB_IDLE;
          wr_stb_next = 1'b1;
        end
      end
      default: acc_next = RHB_IDLE;
    endcase
    if (rst)
    begin
      acc_next = RHB_IDLE;
      addr_next = '0;
      wdata_next = DATA_RST;
      rd_stb_next = 1'b0;
      wr_stb_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    acc_reg <= acc_next;
    addr_reg <= addr_next;
    wdata_reg <= wdata_next;
    rd_stb_reg <= rd_stb_next;
    wr_stb_reg <= wr_stb_next;
  end

  // ----------------------------------------------------------------
  // data bus drive
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] dout_reg;
  logic [DATA_W-1:0] dout_next;
  logic doe_reg;
  logic doe_next;
  logic [NUM_CLASSES-1:0] irq_status_reg;
  logic osc_run_reg;

  // drive only in a read still in progress; float under power fail
  always_comb
  begin
    doe_next = (acc_reg == RHB_READ) && rd_active && pf_n_s;
    dout_next = dout_reg;
    if (rd_stb_reg)
      dout_next = (addr_reg == STATUS_SEL) ? DATA_W'(irq_status_reg) : reg_rdata;
    if (rst)
    begin
      doe_next = 1'b0;
      dout_next = DATA_RST;
    end
  end

  always_ff @(posedge core_clk)
  begin
    doe_reg <= doe_next;
    dout_reg <= dout_next;
  end

  // ----------------------------------------------------------------
  // interrupt status, clear and outputs
  // ----------------------------------------------------------------
  logic [NUM_CLASSES-1:0] irq_status_next;
  logic [NUM_CLASSES-1:0] evt;
  logic [NUM_CLASSES-1:0] clr;
  logic lock_d_reg;
  logic lock_d_next;
  logic int_oe_reg;
  logic int_oe_next;
  logic mfo_reg;
  logic mfo_next;
  logic mfo_oe_reg;
  logic mfo_oe_next;

  always_comb
  begin
    evt = '0;
    evt[ST_PERIODIC_BIT] = periodic_evt;
    evt[ST_ALARM_BIT] = alarm_evt;
    evt[ST_POWER_FAIL_IN_N_BIT] = lockout_reg && !lock_d_reg;
    clr = '0;
    if (wr_stb_reg && addr_reg == STATUS_SEL)
      clr = wdata_reg[NUM_CLASSES-1:0];
    irq_status_next = (irq_status_reg & ~clr) | evt; // set wins
    int_oe_next = |(irq_status_reg & irq_mask);
    mfo_next = (mfo_mode == MFO_MODE_OSC) ? (osc_s && osc_run_reg) : |(irq_status_reg & mfo_mask);
    mfo_oe_next = battery_standby ? !mfo_next : 1'b1; // open drain only pulls low
    lock_d_next = lockout_reg; // one-shot power-fail event on lockout entry
    if (rst)
    begin
      irq_status_next = STATUS_RST;
      int_oe_next = 1'b0;
      mfo_next = 1'b0;
      mfo_oe_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    irq_status_reg <= irq_status_next;
    int_oe_reg <= int_oe_next;
    mfo_reg <= mfo_next;
    mfo_oe_reg <= mfo_oe_next;
    lock_d_reg <= lock_d_next;
  end

  // ----------------------------------------------------------------
  // oscillator enable
  // ----------------------------------------------------------------
  logic osc_run_next;

  // zero crystal select stops the oscillator
  always_comb
  begin
    osc_run_next = osc_run_reg;
    if (xtal_sel_wr)
      osc_run_next = |xtal_sel;
    if (rst || battery_standby)
      osc_run_next = 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    osc_run_reg <= osc_run_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign host_data_out = dout_reg;
  assign host_data_oe = doe_reg;
  assign reg_rd_stb = rd_stb_reg;
  assign reg_wr_stb = wr_stb_reg;
  assign reg_addr = addr_reg;
  assign reg_wdata = wdata_reg;
  assign irq_status = irq_status_reg;
  assign lockout = lockout_reg;
  assign osc_run = osc_run_reg;
  assign interrupt_out_n = 1'b0; // open drain: only pulls low
  assign interrupt_oe = int_oe_reg;
  assign multi_function_out = mfo_reg;
  assign multi_function_oe = mfo_oe_reg;
endmodule
`default_nettype wire

// *** logic/rhb_pkg.sv ***
// package: constants shared by the rtc host port logic
package rhb_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int LOCKOUT_MIN_US = 30;
  localparam int LOCKOUT_MAX_US = 63;
  // least time rounds up, longest time rounds down
  localparam int LOCKOUT_MIN_CYC = (LOCKOUT_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LOCKOUT_MAX_CYC = (LOCKOUT_MAX_US * 1000000) / CLK_PERIOD_PS;
  localparam int LOCKOUT_CNT_W = 16;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int SEL_W = 5;
  localparam int DATA_W = 8;

  // ----------------------------------------------------------------
  // status and mask bit positions (status byte image)
  // ----------------------------------------------------------------
  localparam int ST_PERIODIC_BIT = 0;
  localparam int ST_ALARM_BIT = 1;
  localparam int ST_POWER_FAIL_IN_N_BIT = 2;
  localparam int NUM_CLASSES = 3;
  localparam logic [SEL_W-1:0] STATUS_SEL = 5'h00;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [NUM_CLASSES-1:0] STATUS_RST = 3'h0;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  // multi-function output modes
  localparam logic MFO_MODE_IRQ = 1'b0;
  localparam logic MFO_MODE_OSC = 1'b1;

  typedef enum logic [1:0] {
    RHB_IDLE = 2'b00,
    RHB_READ = 2'b01,
    RHB_WRITE = 2'b10
  } rhb_acc_t;

endpackage

// *** logic/rhb_sync.sv ***
// two flip-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module rhb_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;

  // next values: first stage only feeds the second
  always_comb
  begin
    meta_next = async_in;
    sync_next = meta_reg;
    if (rst)
    begin
      meta_next = RST_VAL;
      sync_next = RST_VAL;
    end
  end

  // register stages
  always_ff @(posedge core_clk)
  begin
    meta_reg <= meta_next;
    sync_reg <= sync_next;
  end

  assign sync_out = sync_reg;
endmodule
`default_nettype wire

// *** tb/rhb_host_model.sv ***
// host bus controller model driving the port pins
`timescale 1ns/1ps
`default_nettype none
module rhb_host_model (
  input wire logic core_clk,
  output logic chip_sel_n,
  output logic read_n,
  output logic write_n,
  output logic [4:0] register_select_lines,
  output logic [7:0] host_data_in,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe
);
  logic [7:0] dq;
  logic drv;
  // a released bus shows the inverse of the last byte
  assign host_data_in = drv ? dq : ~dq;
  initial
  begin
    chip_sel_n = 1'b1;
    read_n = 1'b1;
    write_n = 1'b1;
    register_select_lines = 5'h00;
    dq = 8'h00;
    drv = 1'b0;
  end
  // one access held len cycles, then the idle gap
  task automatic access(input logic cs_n, input logic wr, input logic [4:0] a, input logic [7:0] d,
                        input int len, output logic [7:0] q, output logic oe);
    @(negedge core_clk);
    register_select_lines = a;
    dq = d;
    drv = wr;
    chip_sel_n = cs_n;
    read_n = wr;
    write_n = !wr;
    repeat (len) @(negedge core_clk);
    q = host_data_out;
    oe = host_data_oe;
    chip_sel_n = 1'b1;
    read_n = 1'b1;
    write_n = 1'b1;
    drv = 1'b0;
    register_select_lines = ~a;
    repeat (6) @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

// *** tb/rhb_host_port_chk.sv ***
// checker: pin-level assertions for the rtc host port
`timescale 1ns/1ps
`default_nettype none
module rhb_host_port_chk #(
  parameter int LOCKOUT_CYC = 20
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic chip_sel_n,
  input wire logic read_n,
  input wire logic write_n,
  input wire logic host_data_oe,
  input wire logic reg_rd_stb,
  input wire logic reg_wr_stb,
  input wire logic power_fail_in_n,
  input wire logic battery_standby,
  input wire logic power_fail_in_n_detect_en,
  input wire logic lockout_delay_en,
  input wire logic periodic_evt,
  input wire logic [2:0] irq_mask,
  input wire logic [2:0] irq_status,
  input wire logic lockout,
  input wire logic osc_run,
  input wire logic interrupt_out_n,
  input wire logic interrupt_oe
);
  int unsigned pf_cnt;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // cycles the power-fail pin has been low
  always_ff @(posedge core_clk)
  begin
    if (rst || power_fail_in_n)
      pf_cnt <= 0;
    else
      pf_cnt <= pf_cnt + 1;
  end
  property p_rd_cause;
    reg_rd_stb |-> $past(!chip_sel_n && !read_n, 2);
  endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("read strobe without select and read low");
  property p_oe_cause;
    $rose(host_data_oe) |-> $past(!chip_sel_n && !read_n, 2);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("data driven outside a read");
  property p_oe_release;
    (chip_sel_n || read_n) [*6] |-> !host_data_oe;
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("data lines not released");
  property p_wr_cause;
    reg_wr_stb |-> $past(!chip_sel_n && !write_n, 6);
  endproperty
  a_wr_cause: assert property (p_wr_cause) else $error("write strobe without a write");
  property p_interrupt_out_n_pin;
    interrupt_out_n == 1'b0 && interrupt_oe == ($past(irq_status & irq_mask) != 3'h0);
  endproperty
  a_interrupt_out_n_pin: assert property (p_interrupt_out_n_pin) else $error("interrupt pin level not low");
  property p_irq_set;
    periodic_evt && irq_mask[0] && !lockout |-> ##[1:3] interrupt_oe;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("enabled event gave no interrupt");
  property p_irq_idle;
    ((irq_status & irq_mask) == 3'h0) [*3] |-> !interrupt_oe;
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("interrupt with no enabled status");
  property p_irq_hold;
    interrupt_oe && !reg_wr_stb && !$past(reg_wr_stb) && !$past(reg_wr_stb, 2) |=> interrupt_oe;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped without a clear");
  property p_lock_min;
    $rose(lockout) |-> pf_cnt >= LOCKOUT_CYC;
  endproperty
  a_lock_min: assert property (p_lock_min) else $error("lockout entered too early");
  property p_lock_max;
    !power_fail_in_n && power_fail_in_n_detect_en && !lockout_delay_en && pf_cnt == LOCKOUT_CYC + 3 |-> lockout;
  endproperty
  a_lock_max: assert property (p_lock_max) else $error("lockout entered too late");
  property p_osc_off;
    battery_standby [*3] |-> !osc_run;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("oscillator running in standby");
endmodule
bind rhb_host_port rhb_host_port_chk #(.LOCKOUT_CYC(LOCKOUT_CYC)) u_chk (
  .core_clk(core_clk),
  .rst(rst),
  .chip_sel_n(chip_sel_n),
  .read_n(read_n),
  .write_n(write_n),
  .host_data_oe(host_data_oe),
  .reg_rd_stb(reg_rd_stb),
  .reg_wr_stb(reg_wr_stb),
  .power_fail_in_n(power_fail_in_n),
  .battery_standby(battery_standby),
  .power_fail_in_n_detect_en(power_fail_in_n_detect_en),
  .lockout_delay_en(lockout_delay_en),
  .periodic_evt(periodic_evt),
  .irq_mask(irq_mask),
  .irq_status(irq_status),
  .lockout(lockout),
  .osc_run(osc_run),
  .interrupt_out_n(interrupt_out_n),
  .interrupt_oe(interrupt_oe)
);
`default_nettype wire

// *** tb/tb_top.sv ***
// testbench for the rtc host port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rhb_pkg::*;
  localparam int LCK = 20;
  logic core_clk, rst, chip_sel_n, read_n, write_n, host_data_oe, power_fail_in_n, battery_standby;
  logic power_fail_in_n_detect_en, lockout_delay_en, reg_rd_stb, reg_wr_stb, periodic_evt, alarm_evt, mfo_mode;
  logic osc_clk_in, xtal_sel_wr, lockout, osc_run, interrupt_out_n, interrupt_oe;
  logic multi_function_out, multi_function_oe, qoe;
  logic [4:0] register_select_lines, reg_addr, rd_addr, wr_addr, a;
  logic [7:0] host_data_in, host_data_out, reg_rdata, reg_wdata, wr_data, d, q;
  logic [15:0] lockout_delay_cyc;
  logic [2:0] irq_mask, mfo_mask, irq_status;
  logic [1:0] xtal_sel;
  int err_total, n_tests, seed, rd_cnt, wr_cnt, n;
  rhb_host_port #(.LOCKOUT_CYC(LCK)) dut (.*);
  rhb_host_model host (.*);
  // register store contents seen at a location
  function automatic logic [7:0] exp_rd(input logic [4:0] ad);
    return {ad, 3'h6} ^ 8'h5a;
  endfunction
  assign reg_rdata = exp_rd(reg_addr);
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial
  begin
    osc_clk_in = 1'b0;
    forever #7 osc_clk_in = ~osc_clk_in;
  end
  // capture strobes from the port where they are settled
  always @(negedge core_clk)
  begin
    if (reg_rd_stb)
    begin
      rd_cnt++;
      rd_addr = reg_addr;
    end
    if (reg_wr_stb)
    begin
      wr_cnt++;
      wr_addr = reg_addr;
      wr_data = reg_wdata;
    end
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    finish_test();
  end
  initial
  begin
    seed = 56842;
    {err_total, n_tests, rd_cnt, wr_cnt} = '0;
    {rst, power_fail_in_n, power_fail_in_n_detect_en} = 3'h7;
    {battery_standby, lockout_delay_en, periodic_evt, alarm_evt, mfo_mode, xtal_sel_wr} = '0;
    {lockout_delay_cyc, xtal_sel, mfo_mask} = '0;
    irq_mask = 3'h7;
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    // random writes and reads, top location first
    for (int i = 0; i < 14; i++)
    begin
      a = (i == 0) ? 5'h1f : 5'h01 + 5'($unsigned($random(seed)) % 31);
      d = 8'($random(seed));
      host.access(1'b0, 1'b1, a, d, 8, q, qoe);
      chk("wr_addr", {3'h0, a}, {3'h0, wr_addr});
      chk("wr_data", d, wr_data);
      chk("wr_one", 8'(i + 1), 8'(wr_cnt));
      host.access(1'b0, 1'b0, a, 8'h00, 8, q, qoe);
      chk("rd_data", exp_rd(a), q);
      chk("rd_addr", {3'h0, a}, {3'h0, rd_addr});
      chk("rd_oe", 8'h01, {7'h0, qoe});
      chk("idle_oe", 8'h00, {7'h0, host_data_oe});
    end
    n = rd_cnt;
    host.access(1'b1, 1'b0, 5'h03, 8'h00, 8, q, qoe);
    chk("no_cs_rd", 8'(n), 8'(rd_cnt));
    chk("no_cs_oe", 8'h00, {7'h0, qoe});
    // periodic and alarm raise, hold and clear
    mfo_mask = 3'h3;
    for (int c = 0; c < 2; c++)
    begin
      periodic_evt = (c == 0);
      alarm_evt = (c == 1);
      @(negedge core_clk);
      {periodic_evt, alarm_evt} = 2'h0;
      repeat (6) @(negedge core_clk);
      chk("irq_oe", 8'h01, {7'h0, interrupt_oe});
      chk("mfo_irq", 8'h01, {7'h0, multi_function_out});
      chk("status", 8'(1 << c), {5'h0, irq_status});
      host.access(1'b0, 1'b0, STATUS_SEL, 8'h00, 8, q, qoe);
      chk("st_rd", 8'(1 << c), q);
      host.access(1'b0, 1'b1, STATUS_SEL, 8'(1 << c), 8, q, qoe);
      chk("irq_clr", 8'h00, {7'h0, interrupt_oe});
    end
    irq_mask = 3'h6;
    periodic_evt = 1'b1;
    @(negedge core_clk);
    periodic_evt = 1'b0;
    repeat (6) @(negedge core_clk);
    chk("masked", 8'h00, {7'h0, interrupt_oe});
    host.access(1'b0, 1'b1, STATUS_SEL, 8'h01, 8, q, qoe);
    irq_mask = 3'h7;
    // oscillator start and push-pull multi-function output
    xtal_sel = 2'h1;
    xtal_sel_wr = 1'b1;
    @(negedge core_clk);
    xtal_sel_wr = 1'b0;
    repeat (8) @(negedge core_clk);
    chk("osc_on", 8'h01, {7'h0, osc_run});
    chk("mfo_pp", 8'h01, {7'h0, multi_function_oe});
    // oscillator routed to the multi-function output must toggle
    mfo_mode = MFO_MODE_OSC;
    n = 0;
    repeat (32)
    begin
      @(negedge core_clk);
      n += multi_function_out;
    end
    chk("mfo_osc", 8'h01, {7'h0, n > 4 && n < 28});
    mfo_mode = MFO_MODE_IRQ;
    // standby: a raised second interrupt releases the open-drain pin
    battery_standby = 1'b1;
    periodic_evt = 1'b1;
    @(negedge core_clk);
    periodic_evt = 1'b0;
    repeat (8) @(negedge core_clk);
    chk("osc_sb", 8'h00, {7'h0, osc_run});
    chk("mfo_od", 8'h00, {7'h0, multi_function_oe});
    battery_standby = 1'b0;
    host.access(1'b0, 1'b1, STATUS_SEL, 8'h01, 8, q, qoe);
    // power fail lockout window, then refused read
    power_fail_in_n = 1'b0;
    repeat (LCK - 4) @(negedge core_clk);
    chk("lock_early", 8'h00, {7'h0, lockout});
    repeat (LCK) @(negedge core_clk);
    chk("lock_in", 8'h01, {7'h0, lockout});
    chk("pf_irq", 8'h01, {7'h0, interrupt_oe & irq_status[2]});
    n = rd_cnt;
    host.access(1'b0, 1'b0, 5'h02, 8'h00, 8, q, qoe);
    chk("lock_rd", 8'(n), 8'(rd_cnt));
    chk("lock_oe", 8'h00, {7'h0, qoe});
    // second reset in mid-run, port usable again
    rst = 1'b1;
    power_fail_in_n = 1'b1;
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    chk("rst_lock", 8'h00, {7'h0, lockout});
    host.access(1'b0, 1'b0, 5'h02, 8'h00, 8, q, qoe);
    chk("rst_rd", exp_rd(5'h02), q);
    finish_test();
  end
endmodule
`default_nettype wire
